/* File: bench/angle_sensor_diag_flags_tb.sv */
// self-checking bench for the diagnostic flag bank
// assumes host_model and the design files are compiled first
`timescale 1ns/1ps
module angle_sensor_diag_flags_tb;
    import diag_pkg::*;
    localparam int PER = 16;
    logic clk, sys_rst, selftest_run, zc_valid, inbound_check_enable;
    logic rd_en, clear_faults, clear_warnings, turns_reset_cmd, frame_accept;
    logic [11:0] field_now, field_floor_limit, field_ceiling_limit, zc_angle, warn_flags;
    logic signed [12:0] temp_raw;
    logic [7:0] rd_addr;
    logic [15:0] rd_data, rd;
    logic [2:0] fault_flags;
    core_events_t core_ev;
    frame_t frame;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] ev_tab [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h06};
    int bit_tab [5] = '{8, 7, 5, 4, 2};
    diag_flags #(.FIELD_PERIOD(PER)) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .core_ev(core_ev),
        .selftest_run(selftest_run),
        .field_now(field_now),
        .field_floor_limit(field_floor_limit),
        .field_ceiling_limit(field_ceiling_limit),
        .temp_raw(temp_raw),
        .zc_valid(zc_valid),
        .zc_angle(zc_angle),
        .frame(frame),
        .inbound_check_enable(inbound_check_enable),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .clear_faults(clear_faults),
        .clear_warnings(clear_warnings),
        .turns_reset_cmd(turns_reset_cmd),
        .rd_data(rd_data),
        .fault_flags(fault_flags),
        .warn_flags(warn_flags),
        .frame_accept(frame_accept)
    );
    host_model u_host (
        .clk(clk),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .clear_faults(clear_faults),
        .clear_warnings(clear_warnings),
        .turns_reset_cmd(turns_reset_cmd),
        .rd_data(rd_data)
    );
    // ==========================================
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_fail++;
            end_sim();
        end
    end
    // ==========================================
    // compare and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_faults;
        check(16'(fault_flags), 16'h0001);
        check(16'(warn_flags), 16'h0000);
        u_host.send_clear(3'b001);
        check(16'(fault_flags), 16'h0000);
        selftest_run = 1'b1;
        wait_n(4);
        selftest_run = 1'b0;
        check(16'(fault_flags), 16'h0000);
        core_ev.rail_low = 1'b1;
        u_host.send_clear(3'b001);
        check(16'(fault_flags), 16'h0004);
        core_ev.rail_low = 1'b0;
        wait_n(3);
        check(16'(fault_flags), 16'h0004);
        u_host.send_clear(3'b001);
        check(16'(fault_flags), 16'h0000);
    endtask
    task automatic t_field;
        field_now = 12'd100;
        wait_n(2 * PER + 2);
        check(16'(fault_flags), 16'h0002);
        u_host.read_reg(8'h2a, rd);
        check(rd, 16'he064);
        field_now = 12'd1500;
        wait_n(2 * PER + 2);
        check(16'(warn_flags), 16'h0002);
        field_now = 12'd600;
        wait_n(2 * PER + 2);
        u_host.send_clear(3'b011);
        check(16'(warn_flags) | 16'(fault_flags), 16'h0000);
        // move the limits across a steady reading
        field_ceiling_limit = 12'd500;
        wait_n(2 * PER + 2);
        check(16'(warn_flags), 16'h0002);
        field_ceiling_limit = 12'd1200;
        field_floor_limit = 12'd700;
        wait_n(2 * PER + 2);
        check(16'(fault_flags), 16'h0002);
        field_floor_limit = 12'd200;
        u_host.send_clear(3'b011);
        check(16'(warn_flags) | 16'(fault_flags), 16'h0000);
    endtask
    task automatic t_reset;
        sys_rst = 1'b1;
        wait_n(2);
        sys_rst = 1'b0;
        wait_n(1);
        check(16'(fault_flags), 16'h0001);
        check(16'(warn_flags), 16'h0000);
        check(rd_data, 16'h0000);
        u_host.send_clear(3'b001);
        check(16'(fault_flags), 16'h0000);
    endtask
    task automatic t_events;
        for (int i = 0; i < 5; i++)
        begin
            core_ev = ev_tab[i];
            wait_n(1);
            core_ev = '0;
            wait_n(2);
            check(16'(warn_flags), 16'h0001 << bit_tab[i]);
            u_host.send_clear(3'b010);
            check(16'(warn_flags), 16'h0000);
        end
        core_ev.turns_wrap = 1'b1;
        wait_n(1);
        core_ev = '0;
        u_host.send_clear(3'b010);
        check(16'(warn_flags), 16'h0001);
        u_host.send_clear(3'b100);
        check(16'(warn_flags), 16'h0000);
    endtask
    task automatic frame_case(input logic [15:0] w, input logic [2:0] q, input logic acc,
        input logic [15:0] wexp);
        frame = {1'b1, w, q};
        wait_n(1);
        frame = {1'b0, ~w, ~q}; // idle lines do not keep the word
        check(16'(frame_accept), 16'(acc));
        check(16'(warn_flags), wexp);
        u_host.send_clear(3'b010);
    endtask
    task automatic t_frames;
        inbound_check_enable = 1'b1;
        frame_case(16'h0123, 3'b110, 1'b1, 16'h0000);
        frame_case(16'h8123, 3'b110, 1'b0, 16'h0800);
        frame_case(16'h0123, 3'b010, 1'b0, 16'h0800);
        frame_case(16'h0123, 3'b111, 1'b0, 16'h0800);
        frame_case(16'h0123, 3'b100, 1'b0, 16'h0400);
        inbound_check_enable = 1'b0;
        frame_case(16'h0123, 3'b100, 1'b1, 16'h0000);
    endtask
    task automatic t_temp(input logic signed [12:0] t, input logic [15:0] exp,
        input logic [15:0] wexp);
        temp_raw = t;
        wait_n(3);
        u_host.read_reg(8'h28, rd);
        check(rd, exp);
        check(16'(warn_flags), wexp);
        temp_raw = 13'sd0;
        u_host.send_clear(3'b010);
    endtask
    task automatic t_turn(input logic [11:0] a, input logic [11:0] b, input logic [15:0] wexp);
        zc_angle = a;
        zc_valid = 1'b1;
        wait_n(1);
        zc_angle = b;
        wait_n(1);
        zc_valid = 1'b0;
        wait_n(2);
        check(16'(warn_flags), wexp);
        u_host.send_clear(3'b010);
    endtask
    task automatic t_regs;
        core_ev.slew_active = 1'b1;
        wait_n(1);
        core_ev = '0;
        u_host.read_reg(8'h26, rd);
        check(rd, 16'hb100);
        u_host.read_reg(8'h2c, rd);
        check(rd, 16'h0000);
        u_host.send_clear(3'b010);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {sys_rst, selftest_run, zc_valid, inbound_check_enable} = 4'b1000;
        core_ev = '0;
        frame = '0;
        field_now = 12'd600;
        field_floor_limit = 12'd200;
        field_ceiling_limit = 12'd1200;
        temp_raw = 13'sd0;
        zc_angle = 12'h000;
        wait_n(8);
        sys_rst = 1'b0;
        wait_n(1);
        t_faults();
        t_field();
        t_events();
        t_frames();
        t_temp(-13'sd700, 16'hfd58, 16'h0040);
        t_temp(13'sd80, 16'hf050, 16'h0000);
        t_temp(13'sd1300, 16'hf4d8, 16'h0040);
        t_turn(12'h000, 12'h700, 16'h0008);
        t_turn(12'h700, 12'h800, 16'h0000);
        t_regs();
        t_reset();
        end_sim();
    end
endmodule

/* File: bench/host_model.sv */
// host side model: register reads and clear commands
// assumes the bench calls its tasks; it drives at the falling edge
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // requests toward the flag bank
    output logic rd_en,
    output logic [7:0] rd_addr,
    output logic clear_faults,
    output logic clear_warnings,
    output logic turns_reset_cmd,
    // answer
    input wire logic [15:0] rd_data
);
    // ==========================================
    // idle levels
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
        {turns_reset_cmd, clear_warnings, clear_faults} = 3'b000;
    end
    // one read, request held over one rising edge
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        rd_addr = ~a; // stale address not kept
        d = rd_data;
    endtask
    // read first, then clear: {turns reset, warnings, faults}
    task automatic send_clear(input logic [2:0] sel);
        logic [15:0] d;
        read_reg(8'h26, d);
        @(negedge clk);
        {turns_reset_cmd, clear_warnings, clear_faults} = sel;
        @(negedge clk);
        {turns_reset_cmd, clear_warnings, clear_faults} = 3'b000;
    endtask
endmodule

/* File: verilog/diag_defines.svh */
// constants for the diagnostic flag and readout register bank
// assumes a 16-bit register path at byte addresses, one clock
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH
// ==========================================
// register addresses
`define ADDR_CAUTION 8'h26
`define ADDR_TEMP 8'h28
`define ADDR_FIELD 8'h2a
// ==========================================
// register tags in bits 15:12
`define TAG_CAUTION 4'hb
`define TAG_TEMP 4'hf
`define TAG_FIELD 4'he
// ==========================================
// fault bit positions
`define FLT_RESTART 0
`define FLT_FIELD_LOW 1
`define FLT_RAIL_LOW 2
// ==========================================
// warning bit positions
`define WRN_TURNS_OVF 0
`define WRN_FIELD_HIGH 1
`define WRN_OVERRUN 2
`define WRN_TURN_STEP 3
`define WRN_CLIP 4
`define WRN_EE_FIX 5
`define WRN_TEMP_RANGE 6
`define WRN_EXT_FAIL 7
`define WRN_SLEW 8
`define WRN_CRC 10
`define WRN_IFACE 11
// ==========================================
// temperature in eighths of a degree relative to 25 C
`define TEMP_MIN_Q3 12'shd58
`define TEMP_MAX_Q3 12'sh4d8
// turn step limit 135 deg in 12-bit angle units
`define TURN_STEP_LIM 12'h600
// field refresh interval
`define FIELD_PERIOD_NS 128000
`define CLK_PERIOD_NS 100
`define FIELD_PERIOD_CYC (`FIELD_PERIOD_NS / `CLK_PERIOD_NS)
// default field thresholds in gauss
`define FIELD_LO_DEF 12'd200
`define FIELD_HI_DEF 12'd1200
`endif

/* File: verilog/diag_flags.sv */
// diagnostic fault, warning and readout registers of the angle sensor
// assumes serial port logic delivers decoded frames and register reads
`timescale 1ns/1ps
`include "diag_defines.svh"
module diag_flags
    import diag_pkg::*;
#(
    parameter int FIELD_PERIOD = `FIELD_PERIOD_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // core conditions
    input wire core_events_t core_ev,
    input wire logic selftest_run,
    input wire logic [11:0] field_now,
    input wire logic [11:0] field_floor_limit,
    input wire logic [11:0] field_ceiling_limit,
    input wire logic signed [12:0] temp_raw,
    input wire logic zc_valid,
    input wire logic [11:0] zc_angle,
    // serial port frames and configuration
    input wire frame_t frame,
    input wire logic inbound_check_enable,
    // register access from port logic
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic clear_faults,
    input wire logic clear_warnings,
    input wire logic turns_reset_cmd,
    // register read data and flag views
    output logic [15:0] rd_data,
    output logic [2:0] fault_flags,
    output logic [11:0] warn_flags,
    output logic frame_accept
);
    typedef struct packed {
        logic [2:0] faults;
        logic [11:0] warns;
        logic [11:0] temp;
        logic [11:0] prev_zc;
        logic zc_seen;
        logic [15:0] rd_data;
        logic accept;
    } flag_state_t;
    flag_state_t st, next_st;
    logic [11:0] field_held;
    logic field_tick;

    // ==========================================
    // field sampler
    field_sampler #(.PERIOD(FIELD_PERIOD)) u_field (
        .clk(clk),
        .sys_rst(sys_rst),
        .field_now(field_now),
        .field_held(field_held),
        .tick(field_tick)
    );

    // circular distance between two 12-bit angles
    function automatic logic [11:0] ang_dist(input logic [11:0] a, input logic [11:0] b);
        logic [11:0] d;
        d = a - b;
        if (d[11])
            d = 12'(-d);
        return d;
    endfunction

    logic frame_bad_iface;
    logic frame_bad_crc;
    logic temp_low;
    logic temp_high;
    logic [11:0] temp_clamped;
    // ==========================================
    // frame checks and temperature clamp
    always_comb
    begin
        frame_bad_iface = frame.done &&
            (!frame.bit_count_ok || frame.word[15] || frame.manchester_err);
        frame_bad_crc = frame.done && inbound_check_enable && !frame.crc_ok;
        temp_low = temp_raw < 13'(signed'(`TEMP_MIN_Q3));
        temp_high = temp_raw > 13'(signed'(`TEMP_MAX_Q3));
        if (temp_low)
            temp_clamped = `TEMP_MIN_Q3;
        else if (temp_high)
            temp_clamped = `TEMP_MAX_Q3;
        else
            temp_clamped = temp_raw[11:0];
    end

    // ==========================================
    // flag latching, set wins over clear
    always_comb
    begin
        next_st = st;
        next_st.temp = temp_clamped;
        next_st.accept = frame.done && !frame_bad_iface && !frame_bad_crc;
        if (clear_faults)
            next_st.faults = '0;
        if (clear_warnings)
            next_st.warns = st.warns & (12'h1 << `WRN_TURNS_OVF);
        if (turns_reset_cmd)
            next_st.warns[`WRN_TURNS_OVF] = 1'b0;
        if (core_ev.rail_low)
            next_st.faults[`FLT_RAIL_LOW] = 1'b1;
        // compare only a fresh sample, never the empty reading after reset
        if (field_tick && field_held < field_floor_limit)
            next_st.faults[`FLT_FIELD_LOW] = 1'b1;
        if (field_tick && field_held > field_ceiling_limit)
            next_st.warns[`WRN_FIELD_HIGH] = 1'b1;
        if (frame_bad_iface || (frame.done && frame.manchester_err))
            next_st.warns[`WRN_IFACE] = 1'b1;
        if (frame_bad_crc)
            next_st.warns[`WRN_CRC] = 1'b1;
        if (core_ev.slew_active)
            next_st.warns[`WRN_SLEW] = 1'b1;
        if (core_ev.ext_cmd_failed)
            next_st.warns[`WRN_EXT_FAIL] = 1'b1;
        if (temp_low || temp_high)
            next_st.warns[`WRN_TEMP_RANGE] = 1'b1;
        if (core_ev.ee_single_fix)
            next_st.warns[`WRN_EE_FIX] = 1'b1;
        if (core_ev.signal_clip)
            next_st.warns[`WRN_CLIP] = 1'b1;
        if (core_ev.ext_start && core_ev.ext_busy)
            next_st.warns[`WRN_OVERRUN] = 1'b1;
        if (core_ev.turns_wrap)
            next_st.warns[`WRN_TURNS_OVF] = 1'b1;
        if (zc_valid)
        begin
            next_st.prev_zc = zc_angle;
            next_st.zc_seen = 1'b1;
            if (st.zc_seen && ang_dist(zc_angle, st.prev_zc) > `TURN_STEP_LIM)
                next_st.warns[`WRN_TURN_STEP] = 1'b1;
        end
        next_st.warns[9] = 1'b0;
        // read mux; writes have no path into these registers
        if (rd_en)
        begin
            unique case (rd_addr)
                `ADDR_CAUTION: next_st.rd_data = {`TAG_CAUTION, st.warns};
                `ADDR_TEMP: next_st.rd_data = {`TAG_TEMP, st.temp};
                `ADDR_FIELD: next_st.rd_data = {`TAG_FIELD, field_held};
                default: next_st.rd_data = 16'h0000;
            endcase
        end
    end

    // ==========================================
    // state register; reset marks the restart flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.faults[`FLT_RESTART] <= 1'b1;
        end
        else
        begin
            st <= next_st; // selftest_run does not touch restart
        end
    end

    assign rd_data = st.rd_data;
    assign fault_flags = st.faults;
    assign warn_flags = st.warns;
    assign frame_accept = st.accept;

    // ==========================================
    // checks
    property p_fault_hold;
        @(posedge clk) disable iff (sys_rst)
        fault_flags[`FLT_RAIL_LOW] && !clear_faults |=> fault_flags[`FLT_RAIL_LOW];
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault flag dropped without clear");

    property p_rail;
        @(posedge clk) disable iff (sys_rst)
        core_ev.rail_low |=> fault_flags[`FLT_RAIL_LOW];
    endproperty
    a_rail: assert property (p_rail)
        else $error("rail low not latched");

    property p_restart;
        @(posedge clk)
        sys_rst |=> fault_flags[`FLT_RESTART];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart flag not set after reset");

    property p_warn_hold;
        @(posedge clk) disable iff (sys_rst)
        warn_flags[`WRN_CLIP] && !clear_warnings |=> warn_flags[`WRN_CLIP];
    endproperty
    a_warn_hold: assert property (p_warn_hold)
        else $error("warning dropped without clear");

    property p_tag;
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_addr == `ADDR_TEMP |=> rd_data[15:12] == `TAG_TEMP;
    endproperty
    a_tag: assert property (p_tag)
        else $error("temperature tag wrong");

    property p_iface;
        @(posedge clk) disable iff (sys_rst)
        frame.done && frame.word[15] |=> warn_flags[`WRN_IFACE] && !frame_accept;
    endproperty
    a_iface: assert property (p_iface)
        else $error("bad frame not flagged");

    property p_crc;
        @(posedge clk) disable iff (sys_rst)
        frame.done && inbound_check_enable && !frame.crc_ok |=> warn_flags[`WRN_CRC];
    endproperty
    a_crc: assert property (p_crc)
        else $error("crc failure not flagged");

    property p_tov;
        @(posedge clk) disable iff (sys_rst)
        warn_flags[`WRN_TURNS_OVF] && !turns_reset_cmd |=> warn_flags[`WRN_TURNS_OVF];
    endproperty
    a_tov: assert property (p_tov)
        else $error("turns overflow cleared without reset command");

    property p_bit9;
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_addr == `ADDR_CAUTION |=> !rd_data[9];
    endproperty
    a_bit9: assert property (p_bit9)
        else $error("unused warning bit read as one");

    property p_selftest;
        @(posedge clk) disable iff (sys_rst)
        selftest_run && !fault_flags[`FLT_RESTART] |=> !fault_flags[`FLT_RESTART];
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("selftest set the restart flag");

    property p_field_low;
        @(posedge clk) disable iff (sys_rst)
        field_tick && field_held < field_floor_limit |=> fault_flags[`FLT_FIELD_LOW];
    endproperty
    a_field_low: assert property (p_field_low)
        else $error("low field not latched");

    property p_field_high;
        @(posedge clk) disable iff (sys_rst)
        field_tick && field_held > field_ceiling_limit |=> warn_flags[`WRN_FIELD_HIGH];
    endproperty
    a_field_high: assert property (p_field_high)
        else $error("high field not latched");

    property p_slew;
        @(posedge clk) disable iff (sys_rst)
        core_ev.slew_active |=> warn_flags[`WRN_SLEW];
    endproperty
    a_slew: assert property (p_slew)
        else $error("slew limiting not latched");

    property p_ext_fail;
        @(posedge clk) disable iff (sys_rst)
        core_ev.ext_cmd_failed |=> warn_flags[`WRN_EXT_FAIL];
    endproperty
    a_ext_fail: assert property (p_ext_fail)
        else $error("extended command failure not latched");

    property p_temp_range;
        @(posedge clk) disable iff (sys_rst)
        temp_low || temp_high |=> warn_flags[`WRN_TEMP_RANGE];
    endproperty
    a_temp_range: assert property (p_temp_range)
        else $error("temperature range not latched");

    property p_temp_clamp;
        @(posedge clk) disable iff (sys_rst)
        $signed(st.temp) >= `TEMP_MIN_Q3 && $signed(st.temp) <= `TEMP_MAX_Q3;
    endproperty
    a_temp_clamp: assert property (p_temp_clamp)
        else $error("temperature outside clamp limits");

    property p_ee_fix;
        @(posedge clk) disable iff (sys_rst)
        core_ev.ee_single_fix |=> warn_flags[`WRN_EE_FIX];
    endproperty
    a_ee_fix: assert property (p_ee_fix)
        else $error("eeprom soft error not latched");

    property p_clip;
        @(posedge clk) disable iff (sys_rst)
        core_ev.signal_clip |=> warn_flags[`WRN_CLIP];
    endproperty
    a_clip: assert property (p_clip)
        else $error("saturation not latched");

    property p_overrun;
        @(posedge clk) disable iff (sys_rst)
        core_ev.ext_start && core_ev.ext_busy |=> warn_flags[`WRN_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("extended access overrun not latched");

    property p_turns_set;
        @(posedge clk) disable iff (sys_rst)
        core_ev.turns_wrap |=> warn_flags[`WRN_TURNS_OVF];
    endproperty
    a_turns_set: assert property (p_turns_set)
        else $error("turns overflow not latched");

    property p_warn_zero;
        @(posedge clk) disable iff (sys_rst)
        !warn_flags[9];
    endproperty
    a_warn_zero: assert property (p_warn_zero)
        else $error("unused warning bit set");

    property p_caution_tag;
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_addr == `ADDR_CAUTION |=> rd_data[15:12] == `TAG_CAUTION;
    endproperty
    a_caution_tag: assert property (p_caution_tag)
        else $error("warning register tag wrong");

    property p_count_bad;
        @(posedge clk) disable iff (sys_rst)
        frame.done && !frame.bit_count_ok |=> warn_flags[`WRN_IFACE] && !frame_accept;
    endproperty
    a_count_bad: assert property (p_count_bad)
        else $error("bad bit count not flagged");

    property p_field_read;
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_addr == `ADDR_FIELD |=> rd_data[11:0] == $past(field_held);
    endproperty
    a_field_read: assert property (p_field_read)
        else $error("field reading not returned");
endmodule

/* File: verilog/diag_pkg.sv */
// types shared by the diagnostic register bank
// assumes the defines header is compiled alongside
package diag_pkg;
    // ==========================================
    // event inputs from the sensor core, one cycle or level
    typedef struct packed {
        logic rail_low;
        logic slew_active;
        logic ext_cmd_failed;
        logic ee_single_fix;
        logic signal_clip;
        logic ext_start;
        logic ext_busy;
        logic turns_wrap;
    } core_events_t;
    // serial frame result from the port logic
    typedef struct packed {
        logic done;
        logic [15:0] word;
        logic bit_count_ok;
        logic crc_ok;
        logic manchester_err;
    } frame_t;
endpackage

/* File: verilog/field_sampler.sv */
// field strength sampler: refreshes a held reading on a fixed tick
// assumes field input is from same clock domain
`timescale 1ns/1ps
`include "diag_defines.svh"
module field_sampler
    import diag_pkg::*;
#(
    parameter int PERIOD = `FIELD_PERIOD_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // field input and held output
    input wire logic [11:0] field_now,
    output logic [11:0] field_held,
    output logic tick
);
    typedef struct packed {
        logic [16:0] count;
        logic [11:0] held;
        logic tick;
    } samp_state_t;
    samp_state_t st, next_st;
    // ==========================================
    // interval counter and capture
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.count == 17'(PERIOD - 1))
        begin
            next_st.count = '0;
            next_st.held = field_now;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.count = st.count + 17'h1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end
    assign field_held = st.held;
    assign tick = st.tick;
    property p_field_period;
        @(posedge clk) disable iff (sys_rst)
        tick |=> !tick [*8];
    endproperty
    a_field_period: assert property (p_field_period)
        else $error("field refresh came too soon");
endmodule
